// ### rtl/bps_cfg.svh
// Constants of the buck protection sequencer: timing, counts, pin indices.
// Assumes a 100 MHz core clock; included by bare name from rtl/.
`ifndef BPS_CFG_SVH
`define BPS_CFG_SVH

`define BPS_CLK_PERIOD_NS   10
`define BPS_CNT_W           3
`define BPS_CNT_MAX         3'h7
`define BPS_CNT_TRIP        3'h6
`define BPS_OSC_PERIOD_CYC  250
`define BPS_DEAD_NS         40
`define BPS_DEAD_CYC        ((`BPS_DEAD_NS + `BPS_CLK_PERIOD_NS - 1) / `BPS_CLK_PERIOD_NS)
`define BPS_SYNC_TO_NS      20000
`define BPS_SYNC_TO_CYC     ((`BPS_SYNC_TO_NS + `BPS_CLK_PERIOD_NS - 1) / `BPS_CLK_PERIOD_NS)
`define BPS_DISCH_NS        2000
`define BPS_DISCH_CYC       ((`BPS_DISCH_NS + `BPS_CLK_PERIOD_NS - 1) / `BPS_CLK_PERIOD_NS)
`define BPS_NUM_IN          7
`define BPS_IN_RAMP         0
`define BPS_IN_OC           1
`define BPS_IN_LOW_RAIL     2
`define BPS_IN_HIGH_RAIL    3
`define BPS_IN_SYNC         4
`define BPS_IN_DUTY_END     5
`define BPS_IN_SS_DONE      6

`endif

// ### rtl/bps_pkg.sv
// Types of the buck protection sequencer.
// Assumes nothing beyond a SystemVerilog compiler.
package bps_pkg;
    typedef enum logic [1:0] {ST_LOCKOUT, ST_RUN, ST_HICCUP} bps_state_t;
    typedef enum logic [2:0] {G_OFF, G_DT_HS, G_HS, G_DT_LS, G_LS}
        bps_gate_t;
endpackage

// ### rtl/bps_sat_counter.sv
// Saturating up/down counter used by the undervoltage and fault filters.
// Assumes up, down and clear come from logic on the same clock.
`timescale 1ns/10ps
module bps_sat_counter #(
    parameter int W = 3
) (
    input  wire logic         i_clk,
    input  wire logic         i_rst_n,
    input  wire logic         i_ce,
    input  wire logic         i_clr,
    input  wire logic         i_up,
    input  wire logic         i_dn,
    output logic [W-1:0]      o_cnt
);
    logic [W-1:0] cnt_r;
    logic [W-1:0] cnt_nxt;

    always_comb
    begin
        cnt_nxt = cnt_r;
        if (i_clr)
            cnt_nxt = '0;
        else if (i_up && !i_dn && cnt_r != {W{1'b1}})
            cnt_nxt = cnt_r + W'(1);
        else if (i_dn && !i_up && cnt_r != '0)
            cnt_nxt = cnt_r - W'(1);
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            cnt_r <= '0;
        else if (i_ce)
            cnt_r <= cnt_nxt;
    end

    assign o_cnt = cnt_r;

    a_cnt_no_wrap: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_ce && !i_clr && cnt_r == {W{1'b1}} && i_up && !i_dn)
        |=> cnt_r == {W{1'b1}})
        else $error("fault or filter counter wrapped at top");
endmodule

// ### rtl/bps_sequencer.sv
// Clocked start-up and fault sequencer of a synchronous buck controller.
// Assumes analog comparator outcomes arrive asynchronously on pins and the
// gate drivers and soft-start switch follow the registered outputs.
`timescale 1ns/10ps
`include "bps_cfg.svh"

// Functional notes
// - Every ramp and switching cycle starts on a master clock pulse.
// - Clock pulse before ramp reaches 90% marks a bad cycle.
// - Low-line filter is a three-bit accumulating counter.
// - Seven good cycles assert power-good and start soft-start.
// - After start, seven bad cycles declare undervoltage.
// - Soft-start held low until both rails and low-line check are good.
// - No switching while the ramp is slower than the clock period.
// - High-side overcurrent ends the switching pulse at once.
// - After overcurrent the high side stays off until next cycle.
// - Fault counter counts up on overcurrent cycles, down otherwise.
// - Fault count of seven starts seven soft-start restart cycles.
// - Both gates stay off during the hiccup restart.
// - Each completed hiccup soft-start cycle decrements the fault count.
// - Fault count back at zero re-enables switching via normal start.
// - Persisting overcurrent counts seven again and re-enters hiccup.
// - An external sync clock replaces the master clock, falling edges.
// - Sync held low lets the internal oscillator run freely.
module bps_sequencer #(
    parameter int OSC_PERIOD = `BPS_OSC_PERIOD_CYC
) (
    input  wire logic I_CORE_CLK,
    input  wire logic I_RESET_N,
    input  wire logic I_CLK_EN,
    input  wire logic I_RAMP_DONE,
    input  wire logic I_HS_OVERCURRENT,
    input  wire logic I_LOW_BYPASS_RAIL_OK,
    input  wire logic I_HIGH_BYPASS_RAIL_OK,
    input  wire logic I_SYNC,
    input  wire logic I_DUTY_END,
    input  wire logic I_SS_DONE,
    output logic      O_HS_GATE,
    output logic      O_LS_GATE,
    output logic      O_POWER_GOOD,
    output logic      O_UNDERVOLTAGE,
    output logic      O_SS_HOLD_LOW,
    output logic      O_HICCUP,
    output logic      O_MASTER_PULSE
);
    localparam int                 CW       = `BPS_CNT_W;
    localparam logic [CW-1:0]      CNT_TRIP = `BPS_CNT_TRIP;
    localparam logic [3:0]         DEAD_CYC = 4'(`BPS_DEAD_CYC);
    localparam logic [11:0]        SYNC_TO  = 12'(`BPS_SYNC_TO_CYC);
    localparam logic [7:0]         DISCH    = 8'(`BPS_DISCH_CYC);
    localparam logic [15:0]        DIV_LAST = 16'(OSC_PERIOD - 1);

    logic [1:0]                    rst_sync_r;
    logic                          rst_n;
    logic [`BPS_NUM_IN-1:0]        meta_r;
    logic [`BPS_NUM_IN-1:0]        in_s;
    logic                          s_ramp, s_oc, s_dend, s_sync, s_ssd;
    logic                          rails_ok;

    // Reset released through two flops; asserted at once
    always_ff @(posedge I_CORE_CLK or negedge I_RESET_N)
    begin
        if (!I_RESET_N)
            rst_sync_r <= 2'h0;
        else if (I_CLK_EN)
            rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
    assign rst_n = rst_sync_r[1];

    // Comparator pins cross into the core clock; meta_r feeds in_s only
    always_ff @(posedge I_CORE_CLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_r <= '0;
            in_s   <= '0;
        end
        else if (I_CLK_EN)
        begin
            meta_r <= {I_SS_DONE, I_DUTY_END, I_SYNC, I_HIGH_BYPASS_RAIL_OK,
                       I_LOW_BYPASS_RAIL_OK, I_HS_OVERCURRENT, I_RAMP_DONE};
            in_s   <= meta_r;
        end
    end
    assign s_ramp   = in_s[`BPS_IN_RAMP];
    assign s_oc     = in_s[`BPS_IN_OC];
    assign s_dend   = in_s[`BPS_IN_DUTY_END];
    assign s_sync   = in_s[`BPS_IN_SYNC];
    assign s_ssd    = in_s[`BPS_IN_SS_DONE];
    assign rails_ok = in_s[`BPS_IN_LOW_RAIL] & in_s[`BPS_IN_HIGH_RAIL];

    // Master clock: internal divider or external sync falling edges
    logic [15:0] div_r, div_nxt;
    logic [11:0] sync_to_r, sync_to_nxt;
    logic        sync_prev_r;
    logic        sync_fall, sync_mode, mpulse;

    always_comb
    begin
        sync_fall   = sync_prev_r & ~s_sync;
        sync_mode   = (sync_to_r != 12'h000);
        sync_to_nxt = sync_to_r;
        if (sync_fall)
            sync_to_nxt = SYNC_TO;
        else if (sync_mode)
            sync_to_nxt = sync_to_r - 12'h001;
        mpulse  = sync_mode ? sync_fall : (div_r == DIV_LAST);
        div_nxt = (mpulse || div_r == DIV_LAST) ? 16'h0000 : div_r + 16'h0001;
    end

    always_ff @(posedge I_CORE_CLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            div_r       <= 16'h0000;
            sync_to_r   <= 12'h000;
            sync_prev_r <= 1'b0;
        end
        else if (I_CLK_EN)
        begin
            div_r       <= div_nxt;
            sync_to_r   <= sync_to_nxt;
            sync_prev_r <= s_sync;
        end
    end

    // Sequencer state, per-cycle flags and filter counter controls
    bps_pkg::bps_state_t st_r, st_nxt;
    bps_pkg::bps_gate_t  gph_r, gph_nxt;
    logic          ramp_seen_r, ramp_seen_nxt;
    logic          oc_seen_r, oc_seen_nxt, stop_r, stop_nxt;
    logic          ssd_prev_r, ssd_rise;
    logic          pg_r, pg_nxt, uv_r, uv_nxt, hold_r, hold_nxt;
    logic          hic_r, mp_r;
    logic [7:0]    disch_r, disch_nxt;
    logic          good, oc_cyc;
    logic          uv_up, uv_dn, uv_clr, flt_up, flt_dn;
    logic [CW-1:0] uv_cnt, flt_cnt;

    bps_sat_counter #(.W(CW)) u_uv_filter (
        .i_clk   (I_CORE_CLK),
        .i_rst_n (rst_n),
        .i_ce    (I_CLK_EN),
        .i_clr   (uv_clr),
        .i_up    (uv_up),
        .i_dn    (uv_dn),
        .o_cnt   (uv_cnt)
    );

    bps_sat_counter #(.W(CW)) u_fault_counter (
        .i_clk   (I_CORE_CLK),
        .i_rst_n (rst_n),
        .i_ce    (I_CLK_EN),
        .i_clr   (1'b0),
        .i_up    (flt_up),
        .i_dn    (flt_dn),
        .o_cnt   (flt_cnt)
    );

    always_comb
    begin
        // A ramp finish or overcurrent landing on the pulse still counts
        good          = ramp_seen_r | s_ramp;
        oc_cyc        = oc_seen_r | (s_oc & O_HS_GATE);
        ramp_seen_nxt = mpulse ? 1'b0 : good;
        oc_seen_nxt   = mpulse ? 1'b0 : oc_cyc;
        stop_nxt      = mpulse ? 1'b0
                      : stop_r | (O_HS_GATE & (s_oc | s_dend));
        ssd_rise      = s_ssd & ~ssd_prev_r;
        st_nxt        = st_r;
        pg_nxt        = pg_r;
        uv_nxt        = uv_r;
        hold_nxt      = hold_r;
        disch_nxt     = disch_r;
        uv_up         = 1'b0;
        uv_dn         = 1'b0;
        uv_clr        = 1'b0;
        flt_up        = 1'b0;
        flt_dn        = 1'b0;
        unique case (st_r)
            bps_pkg::ST_LOCKOUT:
            begin
                hold_nxt = 1'b1;
                uv_up    = mpulse & good;
                uv_dn    = mpulse & ~good;
                // A count saturated while the rails were low still starts
                if (rails_ok && uv_up && uv_cnt >= CNT_TRIP)
                begin
                    st_nxt   = bps_pkg::ST_RUN;
                    pg_nxt   = 1'b1;
                    uv_nxt   = 1'b0;
                    hold_nxt = 1'b0;
                    uv_clr   = 1'b1;
                end
            end
            bps_pkg::ST_RUN:
            begin
                uv_up  = mpulse & ~good;
                uv_dn  = mpulse & good;
                flt_up = mpulse & oc_cyc;
                flt_dn = mpulse & ~oc_cyc;
                if (!rails_ok)
                begin
                    st_nxt   = bps_pkg::ST_LOCKOUT;
                    pg_nxt   = 1'b0;
                    hold_nxt = 1'b1;
                    uv_clr   = 1'b1;
                end
                else if (uv_up && uv_cnt == CNT_TRIP)
                begin
                    st_nxt   = bps_pkg::ST_LOCKOUT;
                    pg_nxt   = 1'b0;
                    uv_nxt   = 1'b1;
                    hold_nxt = 1'b1;
                    uv_clr   = 1'b1;
                end
                else if (flt_up && flt_cnt == CNT_TRIP)
                begin
                    st_nxt    = bps_pkg::ST_HICCUP;
                    hold_nxt  = 1'b1;
                    disch_nxt = DISCH;
                end
            end
            bps_pkg::ST_HICCUP:
            begin
                // Discharge the soft-start cap, then let it charge fully
                if (disch_r != 8'h00)
                begin
                    disch_nxt = disch_r - 8'h01;
                    hold_nxt  = (disch_r != 8'h01);
                end
                else if (ssd_rise)
                begin
                    flt_dn = 1'b1;
                    if (flt_cnt == {{(CW-1){1'b0}}, 1'b1})
                    begin
                        st_nxt   = bps_pkg::ST_LOCKOUT;
                        pg_nxt   = 1'b0;
                        hold_nxt = 1'b1;
                        uv_clr   = 1'b1;
                    end
                    else
                    begin
                        disch_nxt = DISCH;
                        hold_nxt  = 1'b1;
                    end
                end
            end
        endcase
        // Rails lost in hiccup: keep the pin low and restart the discharge
        if (!rails_ok && st_nxt == bps_pkg::ST_HICCUP)
        begin
            hold_nxt  = 1'b1;
            disch_nxt = DISCH;
        end
    end

    // Gate sequencing; dead-time phases G_DT_HS and G_DT_LS give break-before-make by design
    logic [3:0] dt_r, dt_nxt;
    logic       run_en;

    always_comb
    begin
        run_en  = (st_nxt == bps_pkg::ST_RUN) && pg_nxt;
        gph_nxt = gph_r;
        dt_nxt  = dt_r;
        if (!run_en)
            gph_nxt = bps_pkg::G_OFF;
        else
        begin
            unique case (gph_r)
                bps_pkg::G_OFF:
                    if (mpulse)
                    begin
                        gph_nxt = bps_pkg::G_DT_HS;
                        dt_nxt  = DEAD_CYC;
                    end
                bps_pkg::G_DT_HS:
                    if (dt_r <= 4'h1)
                        gph_nxt = bps_pkg::G_HS;
                    else
                        dt_nxt = dt_r - 4'h1;
                bps_pkg::G_HS:
                    if (s_oc || s_dend || stop_r)
                    begin
                        gph_nxt = bps_pkg::G_DT_LS;
                        dt_nxt  = DEAD_CYC;
                    end
                bps_pkg::G_DT_LS:
                    if (dt_r <= 4'h1)
                        gph_nxt = bps_pkg::G_LS;
                    else
                        dt_nxt = dt_r - 4'h1;
                bps_pkg::G_LS:
                    if (mpulse)
                    begin
                        gph_nxt = bps_pkg::G_DT_HS;
                        dt_nxt  = DEAD_CYC;
                    end
                default:
                    gph_nxt = bps_pkg::G_OFF;
            endcase
        end
    end

    always_ff @(posedge I_CORE_CLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_r           <= bps_pkg::ST_LOCKOUT;
            gph_r          <= bps_pkg::G_OFF;
            dt_r           <= 4'h0;
            ramp_seen_r    <= 1'b0;
            oc_seen_r      <= 1'b0;
            stop_r         <= 1'b0;
            ssd_prev_r     <= 1'b0;
            pg_r           <= 1'b0;
            uv_r           <= 1'b0;
            hold_r         <= 1'b1;
            hic_r          <= 1'b0;
            mp_r           <= 1'b0;
            disch_r        <= 8'h00;
            O_HS_GATE      <= 1'b0;
            O_LS_GATE      <= 1'b0;
        end
        else if (I_CLK_EN)
        begin
            st_r           <= st_nxt;
            gph_r          <= gph_nxt;
            dt_r           <= dt_nxt;
            ramp_seen_r    <= ramp_seen_nxt;
            oc_seen_r      <= oc_seen_nxt;
            stop_r         <= stop_nxt;
            ssd_prev_r     <= s_ssd;
            pg_r           <= pg_nxt;
            uv_r           <= uv_nxt;
            hold_r         <= hold_nxt;
            hic_r          <= (st_nxt == bps_pkg::ST_HICCUP);
            mp_r           <= mpulse;
            disch_r        <= disch_nxt;
            O_HS_GATE      <= (gph_nxt == bps_pkg::G_HS);
            O_LS_GATE      <= (gph_nxt == bps_pkg::G_LS);
        end
    end

    assign O_POWER_GOOD   = pg_r;
    assign O_UNDERVOLTAGE = uv_r;
    assign O_SS_HOLD_LOW  = hold_r;
    assign O_HICCUP       = hic_r;
    assign O_MASTER_PULSE = mp_r;

    default clocking cb @(posedge I_CORE_CLK); endclocking
    default disable iff (!rst_n || !I_CLK_EN);

    a_no_shoot_through: assert property (!(O_HS_GATE && O_LS_GATE))
        else $error("high and low side gates on together");
    a_hiccup_gates_off: assert property (O_HICCUP |-> !O_HS_GATE && !O_LS_GATE)
        else $error("gate driven during hiccup");
    a_oc_ends_pulse: assert property (O_HS_GATE && s_oc |=> !O_HS_GATE)
        else $error("overcurrent did not end the pulse");
    a_oc_stays_off: assert property (stop_r |-> !O_HS_GATE)
        else $error("high side back on before next cycle");
    a_pwm_needs_pg: assert property (O_HS_GATE |-> O_POWER_GOOD)
        else $error("switching without power-good");
    a_pg_on_seven: assert property (st_r == bps_pkg::ST_LOCKOUT && rails_ok
        && mpulse && good && uv_cnt >= CNT_TRIP
        |=> O_POWER_GOOD && !O_SS_HOLD_LOW)
        else $error("seventh good cycle did not start");
    a_uv_on_seven: assert property (st_r == bps_pkg::ST_RUN && rails_ok
        && mpulse && !good && uv_cnt == CNT_TRIP |=> O_UNDERVOLTAGE && !O_POWER_GOOD)
        else $error("seventh bad cycle did not declare undervoltage");
    a_fault_trip: assert property (st_r == bps_pkg::ST_RUN && rails_ok
        && !(mpulse && !good && uv_cnt == CNT_TRIP) && mpulse && oc_cyc
        && flt_cnt == CNT_TRIP |=> O_HICCUP && flt_cnt == `BPS_CNT_MAX)
        else $error("fault count of seven did not start hiccup");
    a_hiccup_exit: assert property (st_r == bps_pkg::ST_HICCUP && disch_r == 8'h00
        && ssd_rise && flt_cnt == 3'h1 |=> !O_HICCUP && flt_cnt == 3'h0)
        else $error("hiccup did not end at zero count");
    a_rails_hold_ss: assert property (!rails_ok |=> O_SS_HOLD_LOW)
        else $error("soft-start released with rails low");

    c_power_good: cover property ($rose(O_POWER_GOOD));
    c_hiccup_in:  cover property ($rose(O_HICCUP));
    c_hiccup_out: cover property ($fell(O_HICCUP));
    c_uv_declare: cover property ($rose(O_UNDERVOLTAGE));
    c_sync_mode:  cover property (sync_mode && mpulse);
endmodule

// ### tb/bps_analog_model.sv
// Behavioural power stage and analog comparators facing the sequencer.
// Assumes the sequencer gate and pulse outputs; updates on the falling
// core clock edge so that every comparator level is settled at sampling.
`timescale 1ns/10ps
module bps_analog_model (
    input  wire logic       i_clk,
    input  wire logic       i_hs_gate,
    input  wire logic       i_ss_hold_low,
    input  wire logic       i_master_pulse,
    input  wire logic       i_oc_en,
    input  wire logic [7:0] i_ramp_cyc,
    input  wire logic [7:0] i_duty_cyc,
    input  wire logic [7:0] i_ss_cyc,
    output logic            o_ramp_done,
    output logic            o_overcurrent,
    output logic            o_duty_end,
    output logic            o_ss_done
);
    logic [7:0] ramp_t = 8'h00;
    logic [7:0] on_t   = 8'h00;
    logic [7:0] ss_t   = 8'h00;

    // Ramp restarts at each master pulse; a slow ramp never trips in time
    always @(negedge i_clk)
    begin
        ramp_t <= i_master_pulse ? 8'h00
                                 : ramp_t + {7'h00, ramp_t != 8'hff};
        on_t   <= i_hs_gate ? on_t + {7'h00, on_t != 8'hff} : 8'h00;
        ss_t   <= i_ss_hold_low ? 8'h00 : ss_t + {7'h00, ss_t != 8'hff};
    end

    assign o_ramp_done   = ramp_t >= i_ramp_cyc;
    // Switch current only builds while the high side conducts
    assign o_overcurrent = i_oc_en & i_hs_gate & (on_t >= 8'h02);
    assign o_duty_end    = i_hs_gate & (on_t >= i_duty_cyc);
    assign o_ss_done     = ~i_ss_hold_low & (ss_t >= i_ss_cyc);
endmodule

// ### tb/bps_sequencer_tb.sv
// Self-checking bench of the buck protection sequencer.
// Assumes rtl/ on the include path; the analog side is a behavioural model.
`timescale 1ns/10ps
`include "bps_cfg.svh"
module bps_sequencer_tb;
    localparam int OSC   = 20;
    localparam int LIMIT = 30000;
    localparam logic [7:0] SLOW = 8'hc8;
    localparam logic [7:0] FAST = 8'h05;

    logic       clk       = 1'b0;
    logic       rst_n     = 1'b0;
    logic [1:0] rails     = 2'b00;
    logic       sync_on   = 1'b0;
    logic [3:0] sync_div  = 4'h0;
    logic       sync_pin  = 1'b0;
    logic       oc_en     = 1'b0;
    logic [7:0] ramp_cyc  = SLOW;
    logic [7:0] duty_cyc  = 8'h08;
    logic [7:0] ss_cyc    = 8'h0a;
    logic       ce        = 1'b1;
    logic       ramp_done;
    logic       overcur;
    logic       duty_end;
    logic       ss_done;
    logic       hs;
    logic       ls;
    logic       pg;
    logic       uv;
    logic       hold;
    logic       hiccup;
    logic       pulse;
    int         fails     = 0;
    int         tests_run = 0;
    int         cyc       = 0;
    int         gap       = 255;
    int         rel_cnt   = 0;
    logic       prev_hold = 1'b1;
    logic       hs_seen   = 1'b0;

    bps_sequencer #(.OSC_PERIOD(OSC)) u_dut (
        .I_CORE_CLK            (clk),
        .I_RESET_N             (rst_n),
        .I_CLK_EN              (ce),
        .I_RAMP_DONE           (ramp_done),
        .I_HS_OVERCURRENT      (overcur),
        .I_LOW_BYPASS_RAIL_OK  (rails[0]),
        .I_HIGH_BYPASS_RAIL_OK (rails[1]),
        .I_SYNC                (sync_pin),
        .I_DUTY_END            (duty_end),
        .I_SS_DONE             (ss_done),
        .O_HS_GATE             (hs),
        .O_LS_GATE             (ls),
        .O_POWER_GOOD          (pg),
        .O_UNDERVOLTAGE        (uv),
        .O_SS_HOLD_LOW         (hold),
        .O_HICCUP              (hiccup),
        .O_MASTER_PULSE        (pulse)
    );

    bps_analog_model u_model (
        .i_clk          (clk),
        .i_hs_gate      (hs),
        .i_ss_hold_low  (hold),
        .i_master_pulse (pulse),
        .i_oc_en        (oc_en),
        .i_ramp_cyc     (ramp_cyc),
        .i_duty_cyc     (duty_cyc),
        .i_ss_cyc       (ss_cyc),
        .o_ramp_done    (ramp_done),
        .o_overcurrent  (overcur),
        .o_duty_end     (duty_end),
        .o_ss_done      (ss_done)
    );

    initial
    begin
        forever #5 clk = ~clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
            fails++;
        end
    endtask

    task automatic test_done();
        if (fails == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic wait_p(input int n);
        repeat (n) @(negedge clk iff pulse === 1'b1);
        repeat (2) @(negedge clk);
    endtask

    task automatic meas(output int c);
        @(negedge clk iff pulse === 1'b1);
        c = 0;
        do
        begin
            @(negedge clk);
            c++;
        end while (pulse !== 1'b1);
    endtask

    // Sync pin at 16 core cycles, faster than the free-run period
    always @(negedge clk)
    begin
        sync_div <= sync_on ? sync_div + 4'h1 : 4'h0;
        sync_pin <= sync_on & sync_div[3];
    end

    // Gate monitors run all the time; both-off gap counted in samples
    always @(negedge clk)
    begin
        if (hs === 1'b1 && ls === 1'b1)
            chk(2'b11, 2'b00);
        if (hiccup === 1'b1 && (hs | ls) !== 1'b0)
            chk({hs, ls}, 2'b00);
        if (hs === 1'b1)
            hs_seen = 1'b1;
        if ((hs | ls) === 1'b1)
        begin
            if (gap > 0 && gap < `BPS_DEAD_CYC)
                chk(gap, `BPS_DEAD_CYC);
            gap = 0;
        end
        else if (gap < 255)
            gap++;
        if (hiccup === 1'b1 && prev_hold === 1'b1 && hold === 1'b0)
            rel_cnt++;
        prev_hold = hold;
    end

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == LIMIT)
        begin
            fails++;
            test_done();
        end
    end

    task automatic t_rails();
        ramp_cyc = FAST;
        rails = 2'b01;
        wait_p(9);
        chk({pg, hold}, 2'b01);
        // Slow ramp drains the filter that saturated above
        rails = 2'b10;
        ramp_cyc = SLOW;
        wait_p(9);
        chk({pg, hold}, 2'b01);
    endtask

    task automatic t_start();
        rails = 2'b11;
        ramp_cyc = SLOW;
        hs_seen = 1'b0;
        wait_p(10);
        chk({pg, hold}, 2'b01);
        chk(hs_seen, 1'b0);
        ramp_cyc = FAST;
        wait_p(6);
        chk(pg, 1'b0);
        wait_p(2);
        chk({pg, hold, uv}, 3'b100);
    endtask

    task automatic t_switch();
        int c;
        @(negedge clk iff pulse === 1'b1);
        c = 0;
        while (hs !== 1'b1 && c < 40)
        begin
            @(negedge clk);
            c++;
        end
        chk(c >= 3 && c <= 6, 1'b1);
    endtask

    task automatic t_uv();
        ramp_cyc = SLOW;
        wait_p(6);
        chk({pg, uv}, 2'b10);
        wait_p(3);
        chk({pg, uv, hold}, 3'b011);
        ramp_cyc = FAST;
        wait_p(9);
        chk({pg, uv, hold}, 3'b100);
    endtask

    task automatic t_oc();
        int c;
        rel_cnt = 0;
        oc_en = 1'b1;
        @(negedge clk iff hs === 1'b1);
        c = 0;
        while (hs === 1'b1)
        begin
            @(negedge clk);
            c++;
        end
        chk(c <= 6, 1'b1);
        while (pulse !== 1'b1)
        begin
            chk(hs, 1'b0);
            @(negedge clk);
        end
        wait_p(4);
        chk(hiccup, 1'b0);
        wait_p(3);
        chk({hiccup, hold}, 2'b11);
        @(negedge clk iff hiccup === 1'b0);
        chk(rel_cnt, 7);
        chk(pg, 1'b0);
        wait_p(9);
        chk({pg, hiccup}, 2'b10);
        wait_p(8);
        chk(hiccup, 1'b1);
        oc_en = 1'b0;
        @(negedge clk iff hiccup === 1'b0);
        wait_p(9);
        chk({pg, hiccup}, 2'b10);
    endtask

    task automatic t_sync();
        int c;
        sync_on = 1'b1;
        wait_p(3);
        meas(c);
        chk(c, 16);
        sync_on = 1'b0;
        repeat (2100) @(negedge clk);
        meas(c);
        meas(c);
        chk(c, OSC);
    endtask

    // Clock enable low must freeze every output, master pulse included
    task automatic t_freeze();
        logic [6:0] snap;
        snap = {hs, ls, pg, uv, hold, hiccup, pulse};
        ce = 1'b0;
        repeat (60) @(negedge clk);
        chk({hs, ls, pg, uv, hold, hiccup, pulse}, snap);
        ce = 1'b1;
    endtask

    initial
    begin
        repeat (2) @(negedge clk);
        chk({hs, ls, pg, uv, hold, hiccup, pulse}, 7'b0000100);
        rst_n = 1'b1;
        t_rails();
        t_start();
        t_switch();
        t_uv();
        t_oc();
        t_sync();
        t_freeze();
        test_done();
    end
endmodule
